// ===== iqsp_consts.vh
// Constants for the IQ serial output port
`ifndef IQSP_CONSTS_VH
`define IQSP_CONSTS_VH
// Frame lengths in bit clocks, 24-bit words
`define IQSP_LEN24_PLAIN 7'd48
`define IQSP_LEN24_PAIR 7'd64
`define IQSP_LEN24_ALT 7'd56
`define IQSP_LEN24_E_PLAIN 7'd69
`define IQSP_LEN24_E_PAIR 7'd89
`define IQSP_LEN24_E_ALT 7'd79
// Frame lengths in bit clocks, 16-bit words
`define IQSP_LEN16_PLAIN 7'd32
`define IQSP_LEN16_PAIR 7'd48
`define IQSP_LEN16_ALT 7'd40
`define IQSP_LEN16_E_PLAIN 7'd49
`define IQSP_LEN16_E_PAIR 7'd69
`define IQSP_LEN16_E_ALT 7'd59
// Idle high bits closing an embedded frame
`define IQSP_IDLE_BITS 7'd10
// Output samples until data is valid after sync release
`define IQSP_SETTLE_SAMPLES 4'd12
// Reset values
`define IQSP_DIV_RESET 4'h1
`define IQSP_DEC_RESET 16'h0258
// Sample words held in the FIFO: I, Q, gain, status
`define IQSP_WORD_W 64
`define IQSP_FIFO_DEPTH 16
`endif

// ===== iqsp_fifo.v
// Parameterised valid/ready FIFO for IQ sample words
`timescale 1ns/1ns
module iqsp_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	input wire clr,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr_reg;
	reg [AW-1:0] rptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	// No accepts while clearing, so a sample is never taken and then lost
	assign in_ready = (count_reg != DEPTH) && !clr;
	assign out_valid = (count_reg != 0);
	assign out_data = mem[rptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Storage write, no reset needed on data
	always @(posedge mclk) begin
		if (push) begin
			mem[wptr_reg] <= in_data;
		end
	end

	// Pointers and occupancy
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else if (clr) begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // iqsp_fifo

// ===== iqsp_port.v
// IQ serial output port: framing, bit clock, sync and standby
`timescale 1ns/1ns
`include "iqsp_consts.vh"
module iqsp_port (
	// Clock and reset
	input wire mclk,
	input wire rstn,
	// Sync pin, asynchronous, active low
	input wire sync_clear_n,
	// Configuration
	input wire [15:0] decimation_factor,
	input wire [3:0] bit_rate_divisor,
	input wire embedded_framing_enable,
	input wire gain_bytes_enable,
	input wire gain_bytes_alternate,
	input wire word_width_select,
	input wire standby_control,
	// Sample source from the decimator
	input wire sample_valid,
	output wire sample_ready,
	input wire [23:0] sample_i,
	input wire [23:0] sample_q,
	input wire [7:0] gain_byte,
	input wire [7:0] status_byte,
	// Status
	output reg data_valid_reg,
	// Serial link to the host
	output reg serial_clock_out,
	output reg frame_sync_out,
	output reg serial_data_out
);
	// ---------------------------------------------------------------
	// State and declarations
	// ---------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_SHIFT = 3'b010;
	localparam ST_FILL = 3'b100;

	reg [2:0] state_reg;
	reg s1_reg, s2_reg, s3_reg;
	reg sync_n_reg;
	reg [15:0] dec_cnt_reg;
	reg [3:0] div_cnt_reg;
	reg [6:0] bit_cnt_reg;
	reg [6:0] len_reg;
	reg [6:0] content_reg;
	reg [88:0] shift_reg;
	reg alt_sel_reg;
	reg [3:0] settle_reg;
	reg run_reg;
	wire fifo_valid;
	wire [63:0] fifo_data;
	wire frame_tick;
	wire bit_en;
	wire fifo_pop;
	wire fifo_clr;
	reg [88:0] frame_bits;
	reg [6:0] frame_len;
	reg [6:0] frame_content;
	reg [47:0] raw;
	reg [6:0] raw_n;
	integer k;

	// Frame length table, used for both words widths
	function [6:0] iqsp_len;
		input w24;
		input emb;
		input gb;
		input alt;
		begin
			if (w24) begin
				if (!gb) iqsp_len = emb ? `IQSP_LEN24_E_PLAIN : `IQSP_LEN24_PLAIN;
				else if (!alt) iqsp_len = emb ? `IQSP_LEN24_E_PAIR : `IQSP_LEN24_PAIR;
				else iqsp_len = emb ? `IQSP_LEN24_E_ALT : `IQSP_LEN24_ALT;
			end else begin
				if (!gb) iqsp_len = emb ? `IQSP_LEN16_E_PLAIN : `IQSP_LEN16_PLAIN;
				else if (!alt) iqsp_len = emb ? `IQSP_LEN16_E_PAIR : `IQSP_LEN16_PAIR;
				else iqsp_len = emb ? `IQSP_LEN16_E_ALT : `IQSP_LEN16_ALT;
			end
		end
	endfunction

	// ---------------------------------------------------------------
	// Sync pin synchroniser, change accepted when stages two and three agree
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			sync_n_reg <= 1'b0;
		end else begin
			s1_reg <= sync_clear_n;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				sync_n_reg <= s3_reg;
			end
		end
	end

	// Standby freezes everything but FIFO filling; sync low clears the counters
	assign fifo_clr = ~sync_n_reg;
	assign frame_tick = sync_n_reg & ~standby_control & (dec_cnt_reg == 16'h0000);
	assign bit_en = sync_n_reg & ~standby_control & (div_cnt_reg == 4'h0);
	assign fifo_pop = frame_tick & fifo_valid;

	// ---------------------------------------------------------------
	// Sample FIFO between decimator and shifter
	// ---------------------------------------------------------------
	iqsp_fifo #(
		.WIDTH(`IQSP_WORD_W),
		.DEPTH(`IQSP_FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.clr(fifo_clr),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.in_data({sample_i, sample_q, gain_byte, status_byte}),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// ---------------------------------------------------------------
	// Frame builder: raw content, then optional start/stop wrapping
	// ---------------------------------------------------------------
	always @* begin
		raw = 48'h0000_0000_0000;
		raw_n = 7'd0;
		frame_bits = {89{1'b1}};
		frame_len = iqsp_len(word_width_select, embedded_framing_enable,
			gain_bytes_enable, gain_bytes_alternate);
		// I then Q, MSB first, then gain bytes
		if (word_width_select) begin
			raw[47:0] = {fifo_data[63:40], fifo_data[39:16]};
			raw_n = 7'd48;
		end else begin
			raw[47:16] = {fifo_data[63:48], fifo_data[39:24]};
			raw_n = 7'd32;
		end
		if (gain_bytes_enable) begin
			if (gain_bytes_alternate) begin
				raw_n = raw_n + 7'd8;
			end else begin
				raw_n = raw_n + 7'd16;
			end
		end
		frame_content = embedded_framing_enable ? (raw_n + (raw_n >> 2)) : raw_n;
		// Place bits MSB first from position 88 downward
		if (!embedded_framing_enable) begin
			frame_bits[88:41] = raw;
			if (gain_bytes_enable) begin
				if (!gain_bytes_alternate) begin
					if (word_width_select) frame_bits[40:25] = fifo_data[15:0];
					else frame_bits[56:41] = fifo_data[15:0];
				end else if (word_width_select) begin
					// Attenuation LSB 0, status LSB 1
					frame_bits[40:33] = alt_sel_reg ? {fifo_data[7:1], 1'b1} : {fifo_data[15:9], 1'b0};
				end else begin
					frame_bits[56:49] = alt_sel_reg ? {fifo_data[7:1], 1'b1} : {fifo_data[15:9], 1'b0};
				end
			end
		end else begin
			// Wrap each byte with start low and stop high
			for (k = 0; k < 8; k = k + 1) begin
				if (k * 8 < raw_n) begin
					frame_bits[88 - k*10] = 1'b0;
					if (k < 6) begin
						frame_bits[87 - k*10 -: 8] = raw[47 - k*8 -: 8];
					end else if (!gain_bytes_alternate) begin
						frame_bits[87 - k*10 -: 8] = (k == 6) ? fifo_data[15:8] : fifo_data[7:0];
					end else begin
						frame_bits[87 - k*10 -: 8] = alt_sel_reg ? {fifo_data[7:1], 1'b1} : {fifo_data[15:9], 1'b0};
					end
					frame_bits[79 - k*10] = 1'b1;
				end
			end
			if (!word_width_select) begin
				// 16-bit content: slide the gain bytes up behind Q
				for (k = 4; k < 8; k = k + 1) begin
					if (k * 8 < raw_n) begin
						frame_bits[88 - k*10] = 1'b0;
						frame_bits[87 - k*10 -: 8] = (!gain_bytes_alternate) ?
							((k == 4) ? fifo_data[15:8] : fifo_data[7:0]) :
							(alt_sel_reg ? {fifo_data[7:1], 1'b1} : {fifo_data[15:9], 1'b0});
						frame_bits[79 - k*10] = 1'b1;
					end else begin
						frame_bits[88 - k*10 -: 10] = {10{1'b1}};
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Decimation and bit-rate counters
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dec_cnt_reg <= 16'h0000;
			div_cnt_reg <= 4'h0;
		end else if (!sync_n_reg) begin
			dec_cnt_reg <= 16'h0000;
			div_cnt_reg <= 4'h0;
		end else if (!standby_control) begin
			// Period equals the decimation factor, reloaded from it at each frame tick
			if (dec_cnt_reg == 16'h0000) dec_cnt_reg <= decimation_factor - 16'h0001;
			else dec_cnt_reg <= dec_cnt_reg - 16'h0001;
			// Divisor 0 treated as 1, giving a bit tick every mclk
			if (div_cnt_reg == 4'h0) div_cnt_reg <= (bit_rate_divisor == 4'h0) ? 4'h0 : bit_rate_divisor - 4'h1;
			else div_cnt_reg <= div_cnt_reg - 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// Frame state machine and pins
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 7'd0;
			len_reg <= 7'd0;
			content_reg <= 7'd0;
			shift_reg <= {89{1'b1}};
			alt_sel_reg <= 1'b0;
			settle_reg <= 4'h0;
			run_reg <= 1'b0;
			data_valid_reg <= 1'b0;
			serial_clock_out <= 1'b1;
			frame_sync_out <= 1'b0;
			serial_data_out <= 1'b1;
		end else if (!sync_n_reg) begin
			state_reg <= ST_IDLE;
			settle_reg <= 4'h0;
			alt_sel_reg <= 1'b0;
			run_reg <= 1'b0;
			data_valid_reg <= 1'b0;
			serial_clock_out <= 1'b1;
			frame_sync_out <= 1'b0;
			serial_data_out <= 1'b1;
		end else if (!standby_control) begin
			// Rise with each new bit, fall mid-bit so the host samples settled data
			// Limitation: divisor 1 keeps the clock high, a flop cannot toggle at mclk rate
			if (bit_en) begin
				serial_clock_out <= 1'b1;
				run_reg <= 1'b1;
			end else if (run_reg && div_cnt_reg == (bit_rate_divisor >> 1)) begin
				serial_clock_out <= 1'b0;
			end
			// Twelve outputs after release data is trusted again
			if (frame_tick && settle_reg != `IQSP_SETTLE_SAMPLES) begin
				settle_reg <= settle_reg + 4'h1;
			end
			data_valid_reg <= (settle_reg == `IQSP_SETTLE_SAMPLES);
			if (fifo_pop) begin
				shift_reg <= frame_bits;
				len_reg <= frame_len;
				content_reg <= frame_content;
				bit_cnt_reg <= 7'd0;
				state_reg <= ST_SHIFT;
				if (gain_bytes_enable && gain_bytes_alternate) alt_sel_reg <= ~alt_sel_reg;
			end else if (bit_en) begin
				case (state_reg)
					ST_SHIFT: begin
						// Sync pulse one bit long, only without embedding
						frame_sync_out <= (bit_cnt_reg == 7'd0) & ~embedded_framing_enable;
						if (bit_cnt_reg != 7'd0 || embedded_framing_enable) begin
							serial_data_out <= shift_reg[88];
							shift_reg <= {shift_reg[87:0], 1'b1};
						end
						bit_cnt_reg <= bit_cnt_reg + 7'd1;
						if (bit_cnt_reg >= content_reg) state_reg <= ST_FILL;
					end
					ST_FILL: begin
						// Idle highs up to the next frame
						frame_sync_out <= 1'b0;
						serial_data_out <= 1'b1;
						bit_cnt_reg <= bit_cnt_reg + 7'd1;
						if (bit_cnt_reg >= len_reg) state_reg <= ST_IDLE;
					end
					default: begin
						frame_sync_out <= 1'b0;
						serial_data_out <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule // iqsp_port

// ===== iqsp_host_rx.sv
// Host serial receive model for the IQ serial output port
`timescale 1ns/1ns
module iqsp_host_rx (
	// Link pins
	input wire serial_clock_out,
	input wire frame_sync_out,
	input wire serial_data_out,
	// Content length of the mode, 0 for embedded framing
	input wire [6:0] rx_len,
	// Captured frame
	output reg [63:0] rx_word,
	output reg [15:0] rx_frames,
	output reg idle_err
);
	reg [7:0] cnt_reg;
	reg [63:0] sh_reg;
	// Counter parked until the first sync bit, so stray idle bits never count
	initial begin
		cnt_reg = 8'hff;
		sh_reg = 64'h0;
		rx_word = 64'h0;
		rx_frames = 16'h0;
		idle_err = 1'b0;
	end
	// Sample mid-bit on the falling edge; sync bit restarts the count
	always @(negedge serial_clock_out) begin
		if (frame_sync_out) begin
			cnt_reg <= 8'h00;
			sh_reg <= 64'h0;
		end else if (cnt_reg != 8'hff) begin
			cnt_reg <= cnt_reg + 8'h01;
			sh_reg <= {sh_reg[62:0], serial_data_out};
			if (cnt_reg + 8'h01 == {1'b0, rx_len}) begin
				rx_word <= {sh_reg[62:0], serial_data_out};
				rx_frames <= rx_frames + 16'h0001;
			end
			if (rx_len != 7'h00 && cnt_reg >= {1'b0, rx_len} && !serial_data_out)
				idle_err <= 1'b1;
		end
	end
endmodule // iqsp_host_rx

// ===== iqsp_port_properties.sv
// Timing checks on the pins of the IQ serial output port
`timescale 1ns/1ns
module iqsp_port_properties (
	// Clock, reset, sync
	input wire mclk,
	input wire rstn,
	input wire sync_clear_n,
	// Configuration
	input wire [15:0] decimation_factor,
	input wire [3:0] bit_rate_divisor,
	input wire embedded_framing_enable,
	input wire standby_control,
	// Outputs
	input wire data_valid_reg,
	input wire serial_clock_out,
	input wire frame_sync_out,
	input wire serial_data_out
);
	reg [31:0] since;
	wire [3:0] dv = (bit_rate_divisor == 4'h0) ? 4'h1 : bit_rate_divisor;
	wire calm = sync_clear_n && !standby_control && since >= 32'd16;
	reg fs_q, ck_q;
	reg [1:0] q_cnt, k_cnt;
	reg [15:0] fs_gap, ck_gap, fs_hi;
	// Gap counters; rises only count once sync and standby have settled
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{fs_q, ck_q, q_cnt, k_cnt, fs_gap, ck_gap, fs_hi, since} <= 0;
		end else begin
			fs_q <= frame_sync_out;
			ck_q <= serial_clock_out;
			fs_gap <= (frame_sync_out && !fs_q) ? 16'h0001 : fs_gap + 16'h0001;
			ck_gap <= (serial_clock_out && !ck_q) ? 16'h0001 : ck_gap + 16'h0001;
			fs_hi <= frame_sync_out ? fs_hi + 16'h0001 : 16'h0000;
			since <= sync_clear_n ? since + 32'd1 : 32'd0;
			q_cnt <= !calm ? 2'd0 : (frame_sync_out && !fs_q && q_cnt != 2'd3) ? q_cnt + 2'd1 : q_cnt;
			k_cnt <= !calm ? 2'd0 : (serial_clock_out && !ck_q && k_cnt != 2'd3) ? k_cnt + 2'd1 : k_cnt;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Sync waits for the next bit tick, so each start may lag its frame tick by up to one bit
	a_frame_period: assert property (frame_sync_out && !fs_q && q_cnt != 2'd0 && calm |->
		(fs_gap + {12'h000, dv} - 16'h0001) % decimation_factor <= {11'h000, dv, 1'b0} - 16'h0002)
		else $error("frame spacing off");
	a_bit_period: assert property (serial_clock_out && !ck_q && k_cnt != 2'd0 && calm |->
		ck_gap == {12'h000, dv}) else $error("bit clock period off");
	a_sync_width: assert property (!frame_sync_out && fs_q && k_cnt != 2'd0 && calm |->
		fs_hi == {12'h000, dv}) else $error("frame sync width off");
	a_sync_hold: assert property (!sync_clear_n [*6] |-> serial_clock_out && !frame_sync_out)
		else $error("pins not parked during sync");
	a_sync_novalid: assert property (!sync_clear_n [*6] |-> !data_valid_reg)
		else $error("data valid during sync");
	a_valid_late: assert property ($rose(data_valid_reg) |-> since >= 11 * decimation_factor &&
		since <= 12 * decimation_factor + 16) else $error("data valid at wrong time");
	a_clk_restart: assert property ($rose(sync_clear_n) && !standby_control |->
		##[1:40] !serial_clock_out) else $error("bit clock did not restart");
	a_embed_quiet: assert property (embedded_framing_enable && $stable(embedded_framing_enable) |->
		!frame_sync_out) else $error("frame sync with embedded framing");
	a_standby_frozen: assert property (standby_control [*3] |-> $stable(serial_clock_out) &&
		$stable(frame_sync_out) && $stable(serial_data_out)) else $error("pins moved in standby");
	c_frame: cover property (frame_sync_out && !fs_q && q_cnt != 2'd0);
	c_valid: cover property ($rose(data_valid_reg));
	c_standby: cover property (standby_control [*3]);
endmodule // iqsp_port_properties
bind iqsp_port iqsp_port_properties chk_u (.mclk(mclk), .rstn(rstn), .sync_clear_n(sync_clear_n),
	.decimation_factor(decimation_factor), .bit_rate_divisor(bit_rate_divisor),
	.embedded_framing_enable(embedded_framing_enable), .standby_control(standby_control),
	.data_valid_reg(data_valid_reg), .serial_clock_out(serial_clock_out),
	.frame_sync_out(frame_sync_out), .serial_data_out(serial_data_out));

// ===== tb_top.sv
// Self-checking bench for the IQ serial output port
`timescale 1ns/1ns
module tb_top;
	reg mclk = 0, rstn = 0, sync_clear_n = 0, standby_control = 0, sample_valid = 0;
	reg embedded_framing_enable = 0, gain_bytes_enable = 0, gain_bytes_alternate = 0, word_width_select = 0;
	reg [15:0] decimation_factor = 16'h00c8;
	reg [3:0] bit_rate_divisor = 4'h2, dv0 = 4'h2;
	reg [63:0] smp = 64'h0000_0000_0000_0001, s, e;
	reg [6:0] rx_len = 7'h00;
	reg [15:0] base = 0;
	reg pend = 0, fs_d = 0, lastb = 0, got = 0, r = 0;
	reg [2:0] mt [0:6];
	wire sample_ready, data_valid_reg, serial_clock_out, frame_sync_out, serial_data_out, idle_err;
	wire [63:0] rx_word;
	wire [15:0] rx_frames;
	integer fail_count = 0, n_compared = 0, cyc = 0, t_rel = 0, t_first = 0, nz = 0, nz0, m, k, j, acc;
	integer dly [0:6];
	reg [63:0] q [$];
	iqsp_port dut_u (.mclk(mclk), .rstn(rstn), .sync_clear_n(sync_clear_n),
		.decimation_factor(decimation_factor), .bit_rate_divisor(bit_rate_divisor),
		.embedded_framing_enable(embedded_framing_enable), .gain_bytes_enable(gain_bytes_enable),
		.gain_bytes_alternate(gain_bytes_alternate), .word_width_select(word_width_select),
		.standby_control(standby_control), .sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_i(smp[63:40]), .sample_q(smp[39:16]), .gain_byte(smp[15:8]), .status_byte(smp[7:0]),
		.data_valid_reg(data_valid_reg), .serial_clock_out(serial_clock_out),
		.frame_sync_out(frame_sync_out), .serial_data_out(serial_data_out));
	iqsp_host_rx host_u (.serial_clock_out(serial_clock_out), .frame_sync_out(frame_sync_out),
		.serial_data_out(serial_data_out), .rx_len(rx_len), .rx_word(rx_word),
		.rx_frames(rx_frames), .idle_err(idle_err));
	initial forever #5 mclk = ~mclk;
	// First sync after a resync marks the frame base and the start delay
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		fs_d <= frame_sync_out;
		if (frame_sync_out && !fs_d && pend) begin
			t_first <= cyc;
			base <= rx_frames;
			pend <= 0;
		end
	end
	// Low bits seen by the host, proof of embedded traffic
	always @(negedge serial_clock_out) if (!serial_data_out) nz = nz + 1;
	task chk(input string nm, input [63:0] seen, input [63:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			fail_count = fail_count + 1;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Offer one sample for up to n edges; valid is left up for back-to-back use
	task push(input integer n, output reg ok);
		smp = {$urandom, $urandom};
		sample_valid = 1;
		ok = 0;
		for (j = 0; j < n && !ok; j = j + 1) begin
			@(negedge mclk) r = sample_ready;
			@(posedge mclk) ok = r;
		end
		#1;
		if (ok) q.push_back(smp);
	endtask
	// Modes change only while the port is held in sync
	task resync(input [2:0] md, input emb, input [3:0] div);
		sync_clear_n = 0;
		{word_width_select, gain_bytes_enable, gain_bytes_alternate} = md;
		embedded_framing_enable = emb;
		bit_rate_divisor = div;
		rx_len = emb ? 7'd0 : (md[2] ? 7'd48 : 7'd32) + (md[1] ? (md[0] ? 7'd8 : 7'd16) : 7'd0);
		q.delete();
		tick(8);
		sync_clear_n = 1;
		t_rel = cyc;
		pend = 1;
		// Let the synchroniser pass the release before offering samples
		tick(6);
	endtask
	function [63:0] expf(input [63:0] v, input b);
		reg [63:0] x;
		x = word_width_select ? {16'h0000, v[63:16]} : {32'h0000_0000, v[63:48], v[39:24]};
		if (gain_bytes_enable && gain_bytes_alternate) x = {x[55:0], b ? {v[7:1], 1'b1} : {v[15:9], 1'b0}};
		else if (gain_bytes_enable) x = {x[47:0], v[15:0]};
		expf = x;
	endfunction
	task frames(input integer a, input integer b);
		for (k = a; k <= b; k = k + 1) begin
			for (j = 0; (pend || rx_frames - base < k) && j < 1000; j = j + 1) tick(1);
			chk("frame arrived", j < 1000, 1);
			s = q.pop_front();
			// Alternating bytes begin with attenuation after every sync
			e = expf(s, k % 2 == 0);
			chk("frame", rx_word, e);
			if (gain_bytes_alternate && k > a) chk("alternate byte", rx_word[0], !lastb);
			lastb = rx_word[0];
		end
	endtask
	task conclude;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence: every word mode, fill and drain, standby, embedded framing
	initial begin
		{mt[0], mt[1], mt[2], mt[3], mt[4], mt[5], mt[6]} = {3'h4, 3'h6, 3'h7, 3'h0, 3'h2, 3'h3, 3'h4};
		r = $urandom(32'h1ada);
		tick(6);
		rstn = 1;
		for (m = 0; m < 7; m = m + 1) begin
			resync(mt[m], 0, (m == 6) ? dv0 : 4'h2 + 4'($urandom % 2));
			if (m == 0) dv0 = bit_rate_divisor;
			repeat (3) push(50, got);
			sample_valid = 0;
			frames(1, 3);
			dly[m] = t_first - t_rel;
		end
		chk("first frame delay", dly[6], dly[0]);
		resync(3'h6, 0, 4'h3);
		acc = 0;
		got = 1;
		while (got && acc < 20) begin
			push(1, got);
			acc = acc + got;
		end
		sample_valid = 0;
		chk("fifo refuses when full", acc >= 16 && acc <= 17, 1);
		frames(1, acc);
		chk("fifo drained", sample_ready, 1);
		chk("data valid", data_valid_reg, 1);
		standby_control = 1;
		tick(60);
		standby_control = 0;
		push(50, got);
		sample_valid = 0;
		frames(acc + 1, acc + 1);
		resync(3'h4, 1, 4'h2);
		nz0 = nz;
		repeat (2) push(50, got);
		sample_valid = 0;
		tick(600);
		chk("embedded sync pin", frame_sync_out, 0);
		chk("embedded traffic", nz > nz0 + 6, 1);
		chk("idle bits high", idle_err, 0);
		conclude;
	end
	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		fail_count = fail_count + 1;
		conclude;
	end
endmodule // tb_top
